//--- pin_io_pkg.sv
// Constants and types shared by the programmable pin unit
package pin_io_pkg;

  // ==========================================================
  // Pin count and fixed pin numbers
  localparam int unsigned PIN_COUNT = 32;
  localparam logic [31:0] ONE_BIT = 32'h0000_0001;
  localparam int unsigned PIN_TIMER1_OUT = 1;
  localparam int unsigned PIN_DATA_DIR = 4;
  localparam int unsigned PIN_DATA_EN = 5;
  localparam int unsigned PIN_SYNC_READY = 6;
  localparam int unsigned PIN_ADDR17 = 7;
  localparam int unsigned PIN_ADDR18 = 8;
  localparam int unsigned PIN_ADDR19 = 9;
  localparam int unsigned PIN_TIMER0_OUT = 10;
  localparam int unsigned PIN_ZERO_IND = 26;
  localparam int unsigned PIN_STATUS6 = 29;

  // ==========================================================
  // Power-on defaults, one bit per pin
  // Enable: 1 = general-purpose use; normal function on 4..9
  localparam logic [31:0] GP_ENABLE_RESET = ~((ONE_BIT << PIN_DATA_DIR) |
      (ONE_BIT << PIN_DATA_EN) | (ONE_BIT << PIN_SYNC_READY) |
      (ONE_BIT << PIN_ADDR17) | (ONE_BIT << PIN_ADDR18) | (ONE_BIT << PIN_ADDR19));
  // Strap low at reset returns these to normal function
  localparam logic [31:0] STRAP_NORMAL_MASK = (ONE_BIT << PIN_ZERO_IND) |
      (ONE_BIT << PIN_STATUS6);
  // Direction: 1 = output; all inputs after reset
  localparam logic [31:0] GP_OUTPUT_RESET = 32'h0000_0000;
  // Pull: 1 = pullup, 0 = pulldown
  localparam logic [31:0] PULLDOWN_PINS = (ONE_BIT << PIN_TIMER1_OUT) |
      (ONE_BIT << PIN_TIMER0_OUT) | (ONE_BIT << PIN_SYNC_READY);
  localparam logic [31:0] PULL_UP_RESET = ~PULLDOWN_PINS;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  // ==========================================================
  // Reset and restart timing
  localparam logic [19:0] BOOT_ADDRESS = 20'hFFFF0;
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned RESET_HOLD_US = 1000;
  localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_US * (CLOCK_HZ / 1_000_000);
  // Fetch starts about 6.5 output-clock periods after release: on the seventh edge,
  // which is 6 to 7 periods after a release that may fall anywhere in a cycle
  localparam int unsigned FETCH_DELAY_HALF_PERIODS = 13;
  localparam int unsigned FETCH_EDGE_AFTER_RELEASE = (FETCH_DELAY_HALF_PERIODS + 1) / 2;
  // Two synchroniser stages, the step out of the held state, the first compare
  localparam int unsigned RELEASE_EDGES = 4;
  localparam int unsigned DELAY_WIDTH = 4;
  localparam logic [3:0] FETCH_DELAY_LAST = 4'(FETCH_EDGE_AFTER_RELEASE - RELEASE_EDGES);

  // ==========================================================
  // Restart sequence
  typedef enum logic [1:0] {
    RESTART_HELD,
    RESTART_WAIT,
    RESTART_RUN
  } restart_state_type;

endpackage

//--- pin_io_reset_defaults.sv
// Programmable general-purpose pin unit with reset defaults and restart sequencing
// ==========================================================
// ==========================================================
// Pin map: number and the normal function that shares it
// 0: timer 1 input
// 1: timer1_output
// 2: peripheral select 6 or latched address bit 2
// 3: peripheral select 5 or latched address bit 1
// 4: data_direction_pin
// 5: data_enable_pin
// 6: sync_ready_pin
// 7: upper_address_lines bit 17
// 8: upper_address_lines bit 18
// 9: upper_address_lines bit 19
// 10: timer0_output
// 11: timer 0 input
// 12: DMA request 0 or interrupt 5
// 13: DMA request 1 or interrupt 6
// 14: memory select 0
// 15: memory select 1 or upper column strobe
// 16: peripheral select 0
// 17: peripheral select 1
// 18: peripheral select 2 or serial 1 flow control input
// 19: peripheral select 3 or serial 1 flow control output
// 20: serial 0 flow control output
// 21: serial 0 flow control input
// 22: serial 0 transmit data
// 23: serial 0 receive data
// 24: memory select 2 or lower column strobe
// 25: memory select 3 or second row strobe
// 26: upper zero indicator
// 27: serial 1 transmit data
// 28: serial 1 receive data
// 29: bus status bit 6 or clock divide strap
// 30: interrupt 4
// 31: interrupt 2, acknowledge or pulse-width input
module pin_io_reset_defaults (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Configuration from software
  input wire logic [31:0] gp_enable_set,
  input wire logic [31:0] gp_enable_clear,
  input wire logic [31:0] gp_output_set,
  input wire logic [31:0] gp_output_clear,
  input wire logic [31:0] pull_up_set,
  input wire logic [31:0] pull_up_clear,
  input wire logic [31:0] data_write_mask,
  input wire logic [31:0] data_write_value,
  // Strap and pins
  input wire logic high_byte_enable_strap,
  input wire logic [31:0] general_pin_in,
  // Normal functions wanting each pin
  input wire logic [31:0] normal_out,
  input wire logic [31:0] normal_oe,
  // Pin drive
  output logic [31:0] general_pin_out,
  output logic [31:0] general_pin_oe,
  output logic [31:0] pull_up_en,
  output logic [31:0] pull_down_en,
  // Status to software and core
  output logic [31:0] gp_enable,
  output logic [31:0] gp_output,
  output logic [31:0] pin_level,
  output logic [31:0] normal_in,
  output logic core_reset_active,
  output logic fetch_start,
  output logic [19:0] fetch_address
);

  // ==========================================================
  // State
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic strap_seen;
    pin_io_pkg::restart_state_type state;
    logic [pin_io_pkg::DELAY_WIDTH-1:0] delay;
    logic [31:0] enable;
    logic [31:0] output_dir;
    logic [31:0] pull_up;
    logic [31:0] data;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [31:0] pu_en;
    logic [31:0] pd_en;
    logic [31:0] level;
    logic [31:0] to_core;
    logic core_reset;
    logic fetch;
    logic [19:0] address;
  } state_type;

  state_type s_q;
  state_type s_d;

  localparam state_type RESET_STATE = '{
    sync1: 1'b0,
    sync2: 1'b0,
    strap_seen: 1'b0,
    state: pin_io_pkg::RESTART_HELD,
    delay: '0,
    enable: pin_io_pkg::GP_ENABLE_RESET,
    output_dir: pin_io_pkg::GP_OUTPUT_RESET,
    pull_up: pin_io_pkg::PULL_UP_RESET,
    data: pin_io_pkg::DATA_RESET,
    pin_out: '0,
    pin_oe: '0,
    pu_en: '0,
    pd_en: '0,
    level: '0,
    to_core: '0,
    core_reset: 1'b1,
    fetch: 1'b0,
    address: pin_io_pkg::BOOT_ADDRESS
  };

  always_comb begin
    s_d = s_q;
    // Two-stage synchroniser; only sync2 is looked at
    s_d.sync1 = 1'b1;
    s_d.sync2 = s_q.sync1;
    s_d.core_reset = !s_q.sync2;
    s_d.fetch = 1'b0;
    s_d.address = pin_io_pkg::BOOT_ADDRESS;
    case (s_q.state)
      pin_io_pkg::RESTART_HELD: begin
        if (s_q.sync2) begin
          s_d.state = pin_io_pkg::RESTART_WAIT;
          s_d.delay = '0;
          // Strap is caught once, just after release
          if (!s_q.strap_seen) begin
            s_d.strap_seen = 1'b1;
            if (!high_byte_enable_strap) begin
              s_d.enable = s_q.enable & ~pin_io_pkg::STRAP_NORMAL_MASK;
            end
          end
        end
      end
      pin_io_pkg::RESTART_WAIT: begin
        if (s_q.delay == pin_io_pkg::FETCH_DELAY_LAST) begin
          s_d.state = pin_io_pkg::RESTART_RUN;
          s_d.fetch = 1'b1;
        end else begin
          s_d.delay = s_q.delay + 1'b1;
        end
      end
      pin_io_pkg::RESTART_RUN: begin
        // Configuration accepted once running; clear wins over set per bit
        s_d.enable = (s_q.enable | gp_enable_set) & ~gp_enable_clear;
        s_d.output_dir = (s_q.output_dir | gp_output_set) & ~gp_output_clear;
        s_d.pull_up = (s_q.pull_up | pull_up_set) & ~pull_up_clear;
        s_d.data = (s_q.data & ~data_write_mask) | (data_write_value & data_write_mask);
      end
      default: begin
        s_d.state = pin_io_pkg::RESTART_HELD;
      end
    endcase
    // Per-pin mux: each pin number owns one fixed normal function line
    for (int i = 0; i < pin_io_pkg::PIN_COUNT; i++) begin
      if (s_q.enable[i]) begin
        s_d.pin_oe[i] = s_q.output_dir[i];
        s_d.pin_out[i] = s_q.data[i];
        // Pulls act only on general-purpose inputs
        s_d.pu_en[i] = !s_q.output_dir[i] && s_q.pull_up[i];
        s_d.pd_en[i] = !s_q.output_dir[i] && !s_q.pull_up[i];
        s_d.to_core[i] = 1'b0;
      end else begin
        s_d.pin_oe[i] = normal_oe[i];
        s_d.pin_out[i] = normal_out[i];
        s_d.pu_en[i] = 1'b0;
        s_d.pd_en[i] = 1'b0;
        s_d.to_core[i] = general_pin_in[i];
      end
    end
    // No pin is driven until the core leaves reset, whatever the normal functions ask
    if (!s_q.sync2) begin
      s_d.pin_oe = '0;
      s_d.pin_out = '0;
    end
    s_d.level = general_pin_in;
  end

  // Asynchronous reset drops everything to the power-on image at once
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign general_pin_out = s_q.pin_out;
  assign general_pin_oe = s_q.pin_oe;
  assign pull_up_en = s_q.pu_en;
  assign pull_down_en = s_q.pd_en;
  assign gp_enable = s_q.enable;
  assign gp_output = s_q.output_dir;
  assign pin_level = s_q.level;
  assign normal_in = s_q.to_core;
  assign core_reset_active = s_q.core_reset;
  assign fetch_start = s_q.fetch;
  assign fetch_address = s_q.address;

endmodule

//--- pin_io_board_model.sv
// Board-side model resolving each shared pin from unit drive, weak pulls and outside parts
module pin_io_board_model (
  // Drive from the pin unit
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pull_up,
  input wire logic [31:0] pull_down,
  // Outside circuit and resolved level
  input wire logic [31:0] board_value,
  input wire logic [31:0] board_drive,
  output logic [31:0] pin_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // An unheld pin shows the inverse of pin_out, so a missing pull cannot pass as the value the unit presents
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i]) pin_wire[i] = pin_out[i];
      else if (board_drive[i]) pin_wire[i] = board_value[i];
      else if (pull_up[i]) pin_wire[i] = 1'b1;
      else if (pull_down[i]) pin_wire[i] = 1'b0;
      else pin_wire[i] = ~pin_out[i];
    end
  end
endmodule

//--- pin_io_monitor.sv
// Timing and consistency properties of the programmable pin unit
module pin_io_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched ports
  input wire logic [31:0] general_pin_in,
  input wire logic [31:0] general_pin_oe,
  input wire logic [31:0] pull_up_en,
  input wire logic [31:0] pull_down_en,
  input wire logic [31:0] gp_enable,
  input wire logic [31:0] gp_output,
  input wire logic [31:0] pin_level,
  input wire logic core_reset_active,
  input wire logic fetch_start,
  input wire logic [19:0] fetch_address
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence boot_wait;
    !fetch_start [*4];
  endsequence
  a_fetch_after_release: assert property ($fell(core_reset_active) |->
      boot_wait ##1 fetch_start)
    else $error("fetch start not on the seventh edge after release");
  a_fetch_one_pulse: assert property (fetch_start |=> !fetch_start)
    else $error("fetch start longer than one cycle");
  a_fetch_boot_addr: assert property (fetch_start |-> fetch_address == 20'hFFFF0)
    else $error("fetch address not at boot location");
  a_oe_quiet_reset: assert property (core_reset_active |-> general_pin_oe == 32'h0)
    else $error("pin driven while core held in reset");
  a_oe_follows_cfg: assert property ($past(reset_n) |->
      (general_pin_oe & $past(gp_enable)) == $past(gp_enable & gp_output))
    else $error("general output enable does not follow direction");
  a_pulls_exclusive: assert property ((pull_up_en & pull_down_en) == 32'h0)
    else $error("pullup and pulldown on together");
  a_pulls_inputs_only: assert property ($past(reset_n) |->
      ((pull_up_en | pull_down_en) & ~$past(gp_enable & ~gp_output)) == 32'h0)
    else $error("weak pull on a pin that is not a general input");
  a_level_sampled: assert property ($past(reset_n) |->
      pin_level == $past(general_pin_in))
    else $error("pin level not the sampled pin");
endmodule

bind pin_io_reset_defaults pin_io_monitor mon (.clk_sys, .reset_n, .general_pin_in,
  .general_pin_oe, .pull_up_en, .pull_down_en, .gp_enable, .gp_output, .pin_level,
  .core_reset_active, .fetch_start, .fetch_address);

//--- pin_io_reset_defaults_tb.sv
// Self-checking bench for the programmable pin unit
module pin_io_reset_defaults_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic high_byte_enable_strap = 1'b1;
  logic [31:0] gp_enable_set, gp_enable_clear, gp_output_set, gp_output_clear;
  logic [31:0] pull_up_set, pull_up_clear, data_write_mask, data_write_value;
  logic [31:0] normal_out, normal_oe, board_value, board_drive, general_pin_in;
  logic [31:0] general_pin_out, general_pin_oe, pull_up_en, pull_down_en;
  logic [31:0] gp_enable, gp_output, pin_level, normal_in;
  logic core_reset_active, fetch_start;
  logic [19:0] fetch_address;
  int n_mismatch = 0;
  int num_checks = 0;
  // ==========================================================
  // Instances, clock and scenarios
  pin_io_reset_defaults dut (.*);
  pin_io_board_model board (.pin_out(general_pin_out), .pin_oe(general_pin_oe),
    .pull_up(pull_up_en), .pull_down(pull_down_en), .board_value(board_value),
    .board_drive(board_drive), .pin_wire(general_pin_in));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle();
    {gp_enable_set, gp_enable_clear, gp_output_set, gp_output_clear} = 128'h0;
    {pull_up_set, pull_up_clear, data_write_mask, data_write_value} = 128'h0;
  endtask
  task automatic restart(input logic strap);
    int n;
    high_byte_enable_strap = strap;
    reset_n = 1'b0;
    repeat (pin_io_pkg::RESET_HOLD_CYCLES) @(posedge clk_sys);
    #1;
    chk({31'h0, core_reset_active}, 32'h1);
    chk(general_pin_oe, 32'h0);
    reset_n = 1'b1;
    n = 0;
    while (fetch_start !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(32'(n), 32'h7);
    chk({12'h0, fetch_address}, 32'h000F_FFF0);
    chk(gp_enable, strap ? 32'hFFFF_FC0F : 32'hDBFF_FC0F);
    chk(gp_output, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(pull_down_en, 32'h0000_0402);
    chk(pull_up_en, strap ? 32'hFFFF_F80D : 32'hDBFF_F80D);
  endtask
  task automatic drive_and_sense();
    board_drive = 32'h0010_0000;
    normal_oe = 32'h0000_0100;
    normal_out = 32'h0000_0100;
    gp_enable_set = 32'h0000_10C0;
    gp_enable_clear = 32'h0300_9000;
    gp_output_set = 32'h0000_0008;
    pull_up_set = 32'h0000_0080;
    pull_up_clear = 32'h0000_0800;
    data_write_mask = 32'h0000_0008;
    data_write_value = 32'hFFFF_FFFF;
    @(posedge clk_sys);
    #1;
    idle();
    repeat (4) @(posedge clk_sys);
    #1;
    chk(gp_enable & 32'h0000_11C0, 32'h0000_00C0);
    chk(general_pin_oe & 32'h0000_0108, 32'h0000_0108);
    chk(general_pin_out & 32'h0000_0108, 32'h0000_0108);
    chk(pull_up_en & 32'h0000_00C8, 32'h0000_0080);
    chk(pull_down_en & 32'h0000_00C8, 32'h0000_0040);
    chk(pull_down_en & 32'h0000_0800, 32'h0000_0800);
    chk(gp_enable & 32'h0300_8000, 32'h0000_0000);
    chk(normal_in & 32'h0010_0108, 32'h0000_0100);
    chk(pin_level & 32'h0010_00C8, 32'h0000_0088);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    idle();
    {normal_out, normal_oe, board_value, board_drive} = 128'h0;
    restart(1'b1);
    drive_and_sense();
    restart(1'b0);
    tally_and_finish();
  end
  initial begin
    #3_000_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
